/* File: hdl/hrc_controller.sv */
// hibernation controller with one-second rtc, wake logic and apb registers
//
// Behaviour
// - hold open-drain power-off output low while hibernating
// - while hibernating, wake on enabled pin or enabled rtc match
// - on wake release the power-off output so main power returns
// - back-to-back reads are always accepted
// - write-complete clears on a slow-register write, sets after the gap
// - slow clock ticks only while slow clock enable is set
// - select 0 divides input by 128, select 1 uses input directly
// - low battery sets the raw flag when detection is enabled
// - with detection and abort both set, a sleep request under low battery is refused
// - no battery checking while hibernating
// - 32-bit counter advances once per second
// - predivider counts down reference ticks to make the second pulse
// - one second in every 64 uses the trim value as divide count
// - two match registers compare to counter, wake or flag event
// - counter advances only while count enable is set
// - load register write sets the counter at once
// - trim register is readable and writable
// - counting goes on whether hibernating or not
// - sleep request starts hibernation unless aborted
// - pin wake and rtc wake each have their own enable
// - all raw events are ored into one interrupt request
//
// Our own choices: the address map and register access over APB.
module hrc_controller
   import hrc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // slow reference pins
   input wire logic slow_osc_in,
   output logic slow_osc_out,
   // wake and battery inputs
   input wire logic wake_n_in,
   input wire logic low_battery_in,
   // open-drain power-off pin
   output logic power_off_n_out,
   output logic power_off_oe_n,
   // interrupt request
   output logic irq
);

   hrc_state_t s;
   hrc_state_t next_s;

   logic [31:0] mem_rdata;
   logic mem_wr_en;
   logic [5:0] mem_addr;

   // address lies within the retained data words
   function automatic logic in_data(input logic [11:0] a);
      in_data = (a >= OFS_DATA_LO) && (a <= OFS_DATA_HI) && (a[1:0] == 2'b00);
   endfunction

   // address is a register that needs the write gap
   function automatic logic gap_reg(input logic [11:0] a);
      gap_reg = (a == OFS_COUNTER) || (a == OFS_MATCH0) || (a == OFS_MATCH1) ||
                (a == OFS_LOAD) || (a == OFS_TRIM) || in_data(a);
   endfunction

   // address is any mapped register
   function automatic logic mapped(input logic [11:0] a);
      mapped = gap_reg(a) || (a == OFS_CTL) || (a == OFS_RIS);
   endfunction

   // one synchroniser step: level follows once stages two and three agree
   function automatic hrc_sync_t sync_step(input hrc_sync_t q, input logic pin);
      sync_step = q;
      sync_step.s1 = pin;
      sync_step.s2 = q.s1;
      sync_step.s3 = q.s2;
      if (q.s2 == q.s3) begin
         sync_step.level = q.s3;
      end
   endfunction

   // word index into the retained memory
   function automatic logic [5:0] data_index(input logic [11:0] a);
      logic [11:0] d;
      d = a - OFS_DATA_LO;
      data_index = d[7:2];
   endfunction

   // retained data words
   hrc_retained_mem u_mem (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(mem_wr_en),
      .addr(mem_addr),
      .wdata(pwdata),
      .rdata(mem_rdata)
   );

   logic access;
   logic write_fire;
   logic osc_rise;
   logic tick;
   logic second;
   logic hit0;
   logic hit1;
   logic bat_low;
   logic wake_pin;
   logic wake_now;
   logic [31:0] rd_val;

   // memory port driven straight from the bus
   assign access = psel && penable;
   assign write_fire = access && s.pready && pwrite && !s.pslverr;
   assign mem_wr_en = write_fire && in_data(paddr);
   assign mem_addr = data_index(paddr);

   // next state of the whole controller
   always_comb begin
      next_s = s;
      osc_rise = 1'b0;
      tick = 1'b0;
      second = 1'b0;
      rd_val = 32'h0000_0000;

      // pin synchronisers
      next_s.osc = sync_step(s.osc, slow_osc_in);
      next_s.wake = sync_step(s.wake, wake_n_in);
      next_s.bat = sync_step(s.bat, low_battery_in);
      osc_rise = (s.osc.s2 == s.osc.s3) && s.osc.s3 && !s.osc.level;
      wake_pin = !s.wake.level;
      bat_low = s.bat.level && (s.mode == MODE_AWAKE);

      // 32.768 khz reference tick
      if (!s.ctl.slow_clock_enable) begin
         next_s.xdiv = 7'h00;
      end else if (osc_rise) begin
         if (s.ctl.clock_source_select) begin
            tick = 1'b1;
         end else begin
            tick = (s.xdiv == XTAL_DIV_LAST);
            next_s.xdiv = s.xdiv + 7'h01;
         end
      end

      // predivider, runs in every power mode
      if (tick && s.ctl.rtc_count_enable) begin
         if (s.prediv == 16'h0000) begin
            second = 1'b1;
            next_s.sec64 = s.sec64 + 6'h01;
            if (next_s.sec64 == 6'h00) begin
               next_s.prediv = s.trim;
            end else begin
               next_s.prediv = TRIM_NOMINAL;
            end
         end else begin
            next_s.prediv = s.prediv - 16'h0001;
         end
      end

      // seconds counter
      if (second && s.ctl.rtc_count_enable) begin
         next_s.counter = s.counter + 32'h0000_0001;
      end

      // match compare
      hit0 = (s.counter == s.match0);
      hit1 = (s.counter == s.match1);

      // read data mux
      case (paddr)
         OFS_COUNTER: rd_val = s.counter;
         OFS_MATCH0: rd_val = s.match0;
         OFS_MATCH1: rd_val = s.match1;
         OFS_CTL: begin
            rd_val[CTL_MSB:CTL_LSB] = s.ctl;
            rd_val[WRC_BIT] = s.write_complete;
         end
         OFS_RIS: rd_val[RIS_MSB:RIS_LSB] = s.ris;
         OFS_TRIM: rd_val = {16'h0000, s.trim};
         default: begin
            if (in_data(paddr)) begin
               rd_val = mem_rdata;
            end
         end
      endcase

      // apb answer one cycle into the access phase
      next_s.pready = access && !s.pready;
      if (access && !s.pready) begin
         next_s.prdata = rd_val;
         next_s.pslverr = !mapped(paddr);
      end else begin
         next_s.pslverr = 1'b0;
      end

      // register writes
      if (write_fire) begin
         case (paddr)
            OFS_MATCH0: next_s.match0 = pwdata;
            OFS_MATCH1: next_s.match1 = pwdata;
            OFS_LOAD: next_s.counter = pwdata;
            OFS_CTL: next_s.ctl = hrc_ctl_t'(pwdata[CTL_MSB:CTL_LSB]);
            OFS_RIS: next_s.ris = s.ris & ~hrc_ris_t'(pwdata[RIS_MSB:RIS_LSB]);
            OFS_TRIM: next_s.trim = pwdata[15:0];
            default: begin
            end
         endcase
      end

      // write-complete handshake
      if (write_fire && gap_reg(paddr)) begin
         next_s.write_complete = 1'b0;
         next_s.gap_cnt = WRITE_GAP_CYCLES;
      end else if (!s.write_complete) begin
         if (s.gap_cnt <= 16'h0001) begin
            next_s.write_complete = 1'b1;
            next_s.gap_cnt = 16'h0000;
         end else begin
            next_s.gap_cnt = s.gap_cnt - 16'h0001;
         end
      end

      // sticky events, set wins over clear
      if (hit0) begin
         next_s.ris.match_first = 1'b1;
      end
      if (hit1) begin
         next_s.ris.match_second = 1'b1;
      end
      if (s.ctl.low_battery_detect_enable && bat_low) begin
         next_s.ris.low_battery_flag = 1'b1;
      end
      if (wake_pin) begin
         next_s.ris.pin_wake = 1'b1;
      end

      // power mode sequence
      wake_now = (s.ctl.pin_wake_enable && wake_pin) || (s.ctl.rtc_wake_enable && (hit0 || hit1));
      case (s.mode)
         MODE_AWAKE: begin
            if (s.ctl.sleep_request) begin
               if (s.ctl.low_battery_detect_enable && s.ctl.low_battery_abort && bat_low) begin
                  next_s.ctl.sleep_request = 1'b0;
               end else begin
                  next_s.mode = MODE_SLEEP;
               end
            end
         end
         MODE_SLEEP: begin
            if (wake_now) begin
               next_s.mode = MODE_WAKE;
               next_s.ctl.sleep_request = 1'b0;
            end
         end
         MODE_WAKE: begin
            next_s.mode = MODE_AWAKE;
         end
         default: begin
            next_s.mode = MODE_AWAKE;
         end
      endcase

      // pin drivers
      next_s.power_off_n = (next_s.mode != MODE_SLEEP);
      next_s.power_off_oe_n = (next_s.mode != MODE_SLEEP);
      next_s.osc_out = s.ctl.slow_clock_enable && !s.ctl.clock_source_select && !s.osc.level;
      next_s.irq = |next_s.ris;
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
         s.ctl <= CTL_RESET;
         s.mode <= MODE_AWAKE;
         s.counter <= COUNTER_RESET;
         s.match0 <= MATCH_RESET;
         s.match1 <= MATCH_RESET;
         s.trim <= TRIM_NOMINAL;
         s.prediv <= TRIM_NOMINAL;
         s.wake <= '1;
         s.write_complete <= 1'b1;
         s.power_off_n <= 1'b1;
         s.power_off_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state
   assign pready = s.pready;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr;
   assign slow_osc_out = s.osc_out;
   assign power_off_n_out = s.power_off_n;
   assign power_off_oe_n = s.power_off_oe_n;
   assign irq = s.irq;

endmodule // hrc_controller

/* File: hdl/hrc_pkg.sv */
// constants, register layout and shared types of the hibernation rtc controller
package hrc_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_COUNTER = 12'h000;
   localparam logic [11:0] OFS_MATCH0 = 12'h004;
   localparam logic [11:0] OFS_MATCH1 = 12'h008;
   localparam logic [11:0] OFS_LOAD = 12'h00C;
   localparam logic [11:0] OFS_CTL = 12'h010;
   localparam logic [11:0] OFS_RIS = 12'h018;
   localparam logic [11:0] OFS_TRIM = 12'h024;
   localparam logic [11:0] OFS_DATA_LO = 12'h030;
   localparam logic [11:0] OFS_DATA_HI = 12'h12C;

   // field positions
   localparam int CTL_LSB = 0;
   localparam int CTL_MSB = 7;
   localparam int WRC_BIT = 31;
   localparam int RIS_LSB = 0;
   localparam int RIS_MSB = 3;

   // sizes and reset values
   localparam int DATA_WORDS = 64;
   localparam logic [15:0] TRIM_NOMINAL = 16'h7FFF;
   localparam logic [6:0] XTAL_DIV_LAST = 7'h7F;
   localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
   localparam logic [31:0] MATCH_RESET = 32'hFFFF_FFFF;

   // write gap timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_GAP_NS = 2000;
   localparam logic [15:0] WRITE_GAP_CYCLES = 16'((WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // control register, bit 7 down to bit 0
   typedef struct packed {
      logic low_battery_abort;
      logic slow_clock_enable;
      logic low_battery_detect_enable;
      logic pin_wake_enable;
      logic rtc_wake_enable;
      logic clock_source_select;
      logic sleep_request;
      logic rtc_count_enable;
   } hrc_ctl_t;

   localparam hrc_ctl_t CTL_RESET = '0;

   // raw event status, bit 3 down to bit 0
   typedef struct packed {
      logic pin_wake;
      logic low_battery_flag;
      logic match_second;
      logic match_first;
   } hrc_ris_t;

   // power modes, gray along awake, sleep, wake
   typedef enum logic [1:0] {
      MODE_AWAKE = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_WAKE = 2'b11
   } hrc_mode_t;

   // three-stage pin synchroniser with filtered level
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } hrc_sync_t;

   // retained memory state
   typedef struct packed {
      logic [DATA_WORDS-1:0][31:0] word;
      logic [31:0] rdata;
   } hrc_mem_state_t;

   // controller state
   typedef struct packed {
      hrc_ctl_t ctl;
      hrc_ris_t ris;
      hrc_mode_t mode;
      logic [31:0] counter;
      logic [31:0] match0;
      logic [31:0] match1;
      logic [15:0] trim;
      logic [15:0] prediv;
      logic [5:0] sec64;
      logic [6:0] xdiv;
      hrc_sync_t osc;
      hrc_sync_t wake;
      hrc_sync_t bat;
      logic write_complete;
      logic [15:0] gap_cnt;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic power_off_n;
      logic power_off_oe_n;
      logic osc_out;
      logic irq;
   } hrc_state_t;

endpackage

/* File: hdl/hrc_retained_mem.sv */
// retained data word memory with registered read port
module hrc_retained_mem
   import hrc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // access port
   input wire logic wr_en,
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);

   hrc_mem_state_t s;
   hrc_mem_state_t next_s;

   // write selected word, read always
   always_comb begin
      next_s = s;
      if (wr_en) begin
         next_s.word[addr] = wdata;
      end
      next_s.rdata = s.word[addr];
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;

endmodule // hrc_retained_mem

/* File: verif/hrc_controller_sva.sv */
// port-level assertion checker for the hibernation rtc controller
module hrc_controller_sva
   import hrc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // pins and request
   input wire logic slow_osc_in,
   input wire logic slow_osc_out,
   input wire logic wake_n_in,
   input wire logic low_battery_in,
   input wire logic power_off_n_out,
   input wire logic power_off_oe_n,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wctl;
   logic [7:0] sh;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // completed control write
   assign wctl = psel && penable && pready && pwrite && paddr == OFS_CTL;
   // shadow of the written control bits
   always_ff @(posedge clk) begin
      if (!rst_b) sh <= 8'h00;
      else if (wctl) sh <= pwdata[7:0];
   end
   a_ready_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_pin_low: assert property (!power_off_oe_n |-> !power_off_n_out)
      else $error("pin not low");
   a_wake_high: assert property ($rose(power_off_oe_n) |-> power_off_n_out)
      else $error("pin released low");
   a_sleep_go: assert property (wctl && pwdata[1] && !pwdata[7] && power_off_oe_n |-> ##[1:3] !power_off_oe_n)
      else $error("no sleep");
   a_abort_stay: assert property (low_battery_in[*8] ##0 (wctl && pwdata[7] && pwdata[5] && pwdata[1])
      ##0 power_off_oe_n |=> power_off_oe_n[*4])
      else $error("slept on low battery");
   a_osc_gate: assert property (slow_osc_out |-> $past(sh[6] && !sh[2]))
      else $error("crystal drive ungated");
   a_pin_wake: assert property ($fell(wake_n_in) && !power_off_oe_n && sh[4] |-> ##[1:6] power_off_oe_n)
      else $error("no pin wake");
   a_bat_flag: assert property ((sh[5] && low_battery_in && power_off_oe_n)[*8] |-> irq)
      else $error("no low battery event");
   // main scenarios reached
   cover property ($fell(power_off_oe_n));
   cover property (pslverr);
   cover property ($rose(irq));
endmodule // hrc_controller_sva

/* File: verif/hrc_partner.sv */
// regulator, wake source, battery and reference stand-in
module hrc_partner (
   // design pins
   input wire logic clk,
   input wire logic power_off_n_out,
   input wire logic power_off_oe_n,
   output logic slow_osc_in,
   output logic wake_n_in,
   output logic low_battery_in,
   // bench controls
   input wire logic wake_req,
   input wire logic osc_run,
   input wire logic bat_low,
   output logic main_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // regulator enable wire with pull-up
   assign main_on = power_off_oe_n ? 1'b1 : power_off_n_out;
   // battery comparator
   assign low_battery_in = bat_low;
   // half-rate phase of the reference, slow enough for the pin filter
   logic ph;
   initial begin
      slow_osc_in = 1'b0;
      wake_n_in = 1'b1;
      ph = 1'b0;
   end
   // wake held low until power returns; reference at a quarter of clk, low when stopped
   always @(posedge clk) begin
      wake_n_in <= !(wake_req && !main_on);
      ph <= osc_run && !ph;
      if (!osc_run) begin
         slow_osc_in <= 1'b0;
      end else if (ph) begin
         slow_osc_in <= !slow_osc_in;
      end
   end
endmodule // hrc_partner

/* File: verif/tb.sv */
// self-checking bench for the hibernation rtc controller
module tb
   import hrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic wake_req = 1'b0;
   logic osc_run = 1'b0;
   logic bat_low = 1'b0;
   logic pready, pslverr, rerr, main_on, irq;
   logic slow_osc_in, slow_osc_out, wake_n_in, low_battery_in, power_off_n_out, power_off_oe_n;
   logic [31:0] prdata, rdat;
   int error_cnt = 0;
   int tests_run = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   hrc_controller uut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .slow_osc_in, .slow_osc_out, .wake_n_in, .low_battery_in, .power_off_n_out, .power_off_oe_n, .irq);
   hrc_partner u_far (.clk, .power_off_n_out, .power_off_oe_n, .slow_osc_in, .wake_n_in, .low_battery_in,
      .wake_req, .osc_run, .bat_low, .main_on);
   task automatic end_sim();
      $display("tests=%0d errors=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic to();
      error_cnt++;
      end_sim();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) to();
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic wait_wrc();
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_CTL, 32'h0);
         n++;
      end while (rdat[WRC_BIT] !== 1'b1 && n < 100);
      if (n >= 100) to();
   endtask
   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (power_off_oe_n !== v && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) to();
   endtask
   // settling wait after enabling a crystal, plain default
   localparam int XTAL_SETTLE = 64;
   task automatic t_regs();
      rd(OFS_COUNTER, COUNTER_RESET);
      rd(OFS_MATCH0, MATCH_RESET);
      rd(OFS_MATCH1, MATCH_RESET);
      rd(OFS_TRIM, 32'(TRIM_NOMINAL));
      rd(OFS_CTL, 32'h8000_0000);
      apb(1'b0, 12'h014, 32'h0);
      chk(32'(rerr), 32'h1);
      chk(rdat, 32'h0);
      $display("regs done");
   endtask
   task automatic t_load();
      apb(1'b1, OFS_LOAD, 32'h0000_1234);
      rd(OFS_CTL, 32'h0000_0000);
      wait_wrc();
      rd(OFS_COUNTER, 32'h0000_1234);
      apb(1'b1, OFS_MATCH0, 32'h0000_1234);
      wait_wrc();
      rd(OFS_RIS, 32'h0000_0001);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFS_TRIM, 32'h0000_7F00);
      wait_wrc();
      rd(OFS_TRIM, 32'h0000_7F00);
      apb(1'b1, OFS_DATA_LO, 32'hA5A5_0030);
      wait_wrc();
      apb(1'b1, OFS_DATA_HI, 32'h5A5A_012C);
      wait_wrc();
      rd(OFS_DATA_LO, 32'hA5A5_0030);
      rd(OFS_DATA_HI, 32'h5A5A_012C);
      $display("load done");
   endtask
   task automatic t_osc();
      logic [31:0] c [3] = '{32'h40, 32'h44, 32'h00};
      logic [31:0] e [3] = '{32'h1, 32'h0, 32'h0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_CTL, c[i]);
         repeat (XTAL_SETTLE) @(posedge clk);
         chk(32'(slow_osc_out), e[i]);
      end
      // reference running well short of one second: no increment yet
      apb(1'b1, OFS_LOAD, 32'h0000_0010);
      wait_wrc();
      apb(1'b1, OFS_CTL, 32'h0000_0045);
      osc_run <= 1'b1;
      repeat (2000) @(posedge clk);
      rd(OFS_COUNTER, 32'h0000_0010);
      osc_run <= 1'b0;
      apb(1'b1, OFS_CTL, 32'h0000_0000);
      $display("osc done");
   endtask
   task automatic t_pin_wake();
      apb(1'b1, OFS_CTL, 32'h0000_0056);
      wait_oe(1'b0);
      chk(32'(main_on), 32'h0);
      wake_req <= 1'b1;
      wait_oe(1'b1);
      chk(32'(main_on), 32'h1);
      wake_req <= 1'b0;
      rd(OFS_CTL, 32'h8000_0054);
      apb(1'b0, OFS_RIS, 32'h0);
      chk(rdat & 32'h8, 32'h8);
      $display("pin wake done");
   endtask
   task automatic t_rtc_wake();
      // move the first match away from the counter so it cannot wake at once
      apb(1'b1, OFS_MATCH0, MATCH_RESET);
      wait_wrc();
      apb(1'b1, OFS_MATCH1, 32'h0000_0005);
      wait_wrc();
      apb(1'b1, OFS_CTL, 32'h0000_004E);
      wait_oe(1'b0);
      wake_req <= 1'b1;
      repeat (20) @(posedge clk);
      chk(32'(power_off_oe_n), 32'h0);
      wake_req <= 1'b0;
      apb(1'b1, OFS_LOAD, 32'h0000_0005);
      wait_oe(1'b1);
      chk(32'(main_on), 32'h1);
      wait_wrc();
      $display("rtc wake done");
   endtask
   task automatic t_bat();
      // quiet all event sources, then clear the sticky status
      apb(1'b1, OFS_MATCH1, MATCH_RESET);
      wait_wrc();
      apb(1'b1, OFS_RIS, 32'h0000_000F);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      bat_low <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b1, OFS_CTL, 32'h0000_00E6);
      repeat (12) @(posedge clk);
      chk(32'(power_off_oe_n), 32'h1);
      apb(1'b0, OFS_RIS, 32'h0);
      chk(rdat & 32'h4, 32'h4);
      chk(32'(irq), 32'h1);
      bat_low <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b1, OFS_RIS, 32'h0000_0004);
      apb(1'b1, OFS_CTL, 32'h0000_0076);
      wait_oe(1'b0);
      bat_low <= 1'b1;
      repeat (12) @(posedge clk);
      bat_low <= 1'b0;
      repeat (8) @(posedge clk);
      wake_req <= 1'b1;
      wait_oe(1'b1);
      wake_req <= 1'b0;
      apb(1'b0, OFS_RIS, 32'h0);
      chk(rdat & 32'h4, 32'h0);
      $display("battery done");
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_load();
      t_osc();
      t_pin_wake();
      t_rtc_wake();
      t_bat();
      end_sim();
   end
endmodule // tb
bind hrc_controller hrc_controller_sva u_sva (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .prdata, .pslverr, .slow_osc_in, .slow_osc_out, .wake_n_in, .low_battery_in, .power_off_n_out,
   .power_off_oe_n, .irq);
